// *** bench/sdbs_ctrl_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// controller side: turns bench requests into command pins
// ------------------------------------------------------------
module sdbs_ctrl_model
    import sdbs_pkg::*;
(
    input  wire logic              reqValid,
    input  wire logic [2:0]        reqCode,
    input  wire logic [1:0]        reqBank,
    input  wire logic              reqA8,
    input  wire logic [ADDR_W-1:0] reqRand,
    input  wire logic              ckeIn,
    output logic                   clkEnable,
    output logic                   chipSelect_n,
    output logic                   rowStrobe_n,
    output logic                   colStrobe_n,
    output logic                   writeEnable_n,
    output logic                   bankSelectLow,
    output logic                   bankSelectHigh,
    output logic [ADDR_W-1:0]      addr
);
    // between commands the pins show deselect or nop at random, so neither is favoured
    always_comb begin
        clkEnable = ckeIn;
        chipSelect_n = reqValid ? 1'b0 : reqRand[0];
        {rowStrobe_n, colStrobe_n, writeEnable_n} = reqValid ? reqCode : CMD_NOP;
        {bankSelectHigh, bankSelectLow} = reqValid ? reqBank : ~reqBank;
        addr = reqRand;
        addr[AUTO_PRECHARGE_SELECT_BIT] = reqValid ? reqA8 : reqRand[1];
    end
endmodule

// *** bench/sdbs_tracker_test.sv ***
`timescale 1ns/10ps
module sdbs_tracker_test
    import sdbs_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              reqValid = 1'b0;
    logic [2:0]        reqCode = CMD_NOP;
    logic [1:0]        reqBank = 2'h0;
    logic              reqA8 = 1'b0;
    logic [ADDR_W-1:0] reqRand = 12'h000;
    logic              ckeIn = 1'b1;
    logic              clkEnable, chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n;
    logic              bankSelectLow, bankSelectHigh, allBanksIdle, refreshing, modeAccess, prechargeAll;
    logic [ADDR_W-1:0] addr;
    logic [3:0]        bankIdle, bankActive, bankBusy, bankPrechargePhase;
    int                errorCnt = 0;
    int                checksDone = 0;
    int                cycles = 0;
    int                seed = 32'he651;
    int                lat, len, b0;
    logic [3:0]        openMask = 4'h0;

    always #4 clk = ~clk;

    sdbs_ctrl_model ctrl (.reqValid(reqValid), .reqCode(reqCode), .reqBank(reqBank), .reqA8(reqA8),
        .reqRand(reqRand), .ckeIn(ckeIn), .clkEnable(clkEnable), .chipSelect_n(chipSelect_n),
        .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n),
        .bankSelectLow(bankSelectLow), .bankSelectHigh(bankSelectHigh), .addr(addr));

    sdbs_tracker uut (.clk(clk), .rst(rst), .clkEnable(clkEnable), .chipSelect_n(chipSelect_n),
        .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n),
        .bankSelectLow(bankSelectLow), .bankSelectHigh(bankSelectHigh), .addr(addr),
        .bankIdle(bankIdle), .bankActive(bankActive), .bankBusy(bankBusy),
        .bankPrechargePhase(bankPrechargePhase), .allBanksIdle(allBanksIdle),
        .refreshing(refreshing), .modeAccess(modeAccess), .prechargeAll(prechargeAll));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one command; returns in the time step of the edge that takes it
    task automatic issue(input logic [2:0] code, input int bank, input logic a8);
        @(posedge clk);
        reqValid <= 1'b1;
        reqCode <= code;
        reqBank <= bank[1:0];
        reqA8 <= a8;
        reqRand <= 12'($random(seed));
        @(posedge clk);
        reqValid <= 1'b0;
        reqRand <= 12'($random(seed));
    endtask

    function automatic logic pick(input int k, input int b);
        case (k)
            0: return bankActive[b];
            1: return bankBusy[b];
            2: return bankPrechargePhase[b];
            3: return refreshing;
            4: return modeAccess;
            5: return prechargeAll;
            default: return bankIdle[b];
        endcase
    endfunction

    // edges until a level shows, then cycles it stands; sampled at the falling edge
    task automatic span(input int k, input int b, output int l, output int n);
        l = 0;
        n = 0;
        do begin
            @(negedge clk);
            l++;
        end while (pick(k, b) !== 1'b1 && l < 40);
        while (pick(k, b) === 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
    endtask

    // a hang counts as a mismatch and closes the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errorCnt++;
            printVerdict();
        end
    end

    // ------------------------------------------------------------
    // scenarios; commands come once the previous one settles, save the activate slipped into refresh
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("bankIdle", bankIdle, 4'hf);
        check("allBanksIdle", allBanksIdle, 1'b1);
        check("busyOrActive", {bankBusy, bankActive, refreshing, modeAccess, prechargeAll}, 11'h000);
        $display("done: reset levels");
        // open every bank in turn from a random first bank; each busy for the activate delay
        b0 = $unsigned($random(seed)) % 4;
        for (int i = 0; i < 4; i++) begin
            issue(CMD_ACTIVE, (b0 + i) % 4, 1'b0);
            span(1, (b0 + i) % 4, lat, len);
            check("activatingLen", len, ACTIVATE_CYC);
            check("activatingLat", lat, 2);
            check("rowActive", bankActive[(b0 + i) % 4], 1'b1);
            openMask[(b0 + i) % 4] = 1'b1;
            check("othersUntouched", bankIdle, 4'(~openMask));
        end
        $display("done: activate");
        // plain read keeps the row open, then a single-bank precharge
        issue(CMD_READ, 0, 1'b0);
        repeat (12) @(negedge clk);
        check("readKeepsRow", {bankIdle[0], bankBusy[0]}, 2'h0);
        issue(CMD_PRECHARGE, 0, 1'b0);
        span(6, 0, lat, len);
        check("prechargeLat", lat, PRECHARGE_CYC + 2);
        check("othersOpen", bankIdle[3:1], 3'h0);
        $display("done: read and precharge");
        // read with auto precharge returns bank 1 to idle unaided
        issue(CMD_READ, 1, 1'b1);
        span(1, 1, lat, len);
        check("readApBusy", len, READ_ACCESS_CYC + PRECHARGE_CYC);
        check("readApIdle", bankIdle[1], 1'b1);
        // write with auto precharge: phase begins after write recovery
        issue(CMD_WRITE, 2, 1'b1);
        span(2, 2, lat, len);
        check("writeApPhaseLat", lat, WRITE_ACCESS_CYC + 2);
        check("writeApPhaseLen", len, PRECHARGE_CYC);
        check("writeApIdle", bankIdle[2], 1'b1);
        $display("done: auto precharge");
        // plain write on bank 3, then precharge all with a random bank field
        issue(CMD_WRITE, 3, 1'b0);
        repeat (12) @(negedge clk);
        check("writeKeepsRow", bankIdle[3], 1'b0);
        issue(CMD_ACTIVE, 0, 1'b0);
        repeat (6) @(negedge clk);
        issue(CMD_PRECHARGE, $random(seed), 1'b1);
        span(5, 0, lat, len);
        check("prechargeAllLen", len, PRECHARGE_CYC);
        @(negedge clk); // bank flags trail the all-bank flag by one clock
        check("allIdle", {allBanksIdle, bankIdle}, 5'h1f);
        $display("done: precharge all");
        // refresh and mode load, each timed; all banks idle first
        for (int k = 0; k < 2; k++) begin
            issue(k ? CMD_MODE : CMD_REFRESH, 0, 1'b0);
            span(3 + k, 0, lat, len);
            check("allBankStateLen", len, k ? MODESET_CYC : REFRESH_CYC);
            check("idleAfter", {allBanksIdle, bankIdle}, 5'h1f);
        end
        // an activate slipped into refresh is refused
        issue(CMD_REFRESH, 0, 1'b0);
        issue(CMD_ACTIVE, 1, 1'b0);
        repeat (20) @(negedge clk);
        check("refusedInRefresh", bankIdle, 4'hf);
        // clock enable low at the previous edge voids the command
        @(posedge clk);
        ckeIn <= 1'b0;
        fork
            issue(CMD_ACTIVE, 2, 1'b0);
            begin
                @(posedge clk);
                ckeIn <= 1'b1;
            end
        join
        repeat (10) @(negedge clk);
        check("ckeLowIgnored", bankIdle, 4'hf);
        $display("done: all-bank states and clock enable");
        printVerdict();
    end
endmodule

// *** src/sdbs_bank.sv ***
`timescale 1ns/10ps
// one bank's state record and timer
module sdbs_bank
    import sdbs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cmdValid,
    input  wire logic [2:0] cmdCode,
    input  wire logic       autoPre,
    input  wire logic       preSelect,
    output sdbs_bank_e      state,
    output logic            apPrechargePhase
);

    sdbs_bank_e       state_q, state_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic             apPre_q, apPre_d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        tmr_d   = (tmr_q != TMR_ZERO) ? tmr_q - 8'h01 : TMR_ZERO;
        apPre_d = apPre_q;
        unique case (state_q)
            BS_IDLE: begin
                if (cmdValid && cmdCode == CMD_ACTIVE) begin
                    state_d = BS_ACTIVATING;                          // RULE6
                    tmr_d   = TMR_W'(ACTIVATE_CYC - 1);
                end
            end
            BS_ACTIVATING: begin
                if (tmr_q == TMR_ZERO) state_d = BS_ACTIVE;           // RULE6 RULE3
            end
            BS_ACTIVE, BS_READ, BS_WRITE: begin
                if (cmdValid && (cmdCode == CMD_READ || cmdCode == CMD_WRITE)) begin
                    if (autoPre) begin                                // RULE23
                        state_d = (cmdCode == CMD_READ) ? BS_READ_AP : BS_WRITE_AP;
                        tmr_d   = (cmdCode == CMD_READ) ? TMR_W'(READ_ACCESS_CYC - 1)
                                                        : TMR_W'(WRITE_ACCESS_CYC - 1);
                        apPre_d = 1'b0;
                    end else begin
                        state_d = (cmdCode == CMD_READ) ? BS_READ : BS_WRITE; // RULE4
                    end
                end else if (preSelect) begin
                    state_d = BS_PRECHARGING;                          // RULE7
                    tmr_d   = TMR_W'(PRECHARGE_CYC - 1);
                end
            end
            BS_PRECHARGING: begin
                if (tmr_q == TMR_ZERO) state_d = BS_IDLE;             // RULE7 RULE2
            end
            BS_READ_AP, BS_WRITE_AP: begin
                // access period, then precharge period
                if (tmr_q == TMR_ZERO) begin
                    if (!apPre_q) begin
                        apPre_d = 1'b1;                               // RULE19 RULE20 RULE18
                        tmr_d   = TMR_W'(PRECHARGE_CYC - 1);
                    end else begin
                        apPre_d = 1'b0;
                        state_d = BS_IDLE;                            // RULE8
                    end
                end
            end
            default: state_d = BS_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= BS_IDLE;
            tmr_q   <= TMR_ZERO;
            apPre_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
            apPre_q <= apPre_d;
        end
    end

    assign state            = state_q;
    assign apPrechargePhase = apPre_q;

endmodule

// *** src/sdbs_pkg.sv ***
package sdbs_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;               // 125 MHz
    // least times in ps, rounded up to whole cycles
    localparam int PRECHARGE_PERIOD_PS         = 18000;
    localparam int ACTIVATE_TO_ACCESS_DELAY_PS = 18000;
    localparam int REFRESH_CYCLE_TIME_PS       = 60000;
    localparam int MODE_SET_DELAY_PS           = 16000;
    localparam int WRITE_RECOVERY_TIME_PS      = 16000;

    function automatic int cyc(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PRECHARGE_CYC = cyc(PRECHARGE_PERIOD_PS);
    localparam int ACTIVATE_CYC  = cyc(ACTIVATE_TO_ACCESS_DELAY_PS);
    localparam int REFRESH_CYC   = cyc(REFRESH_CYCLE_TIME_PS);
    localparam int MODESET_CYC   = cyc(MODE_SET_DELAY_PS);
    localparam int WRECOVER_CYC  = cyc(WRITE_RECOVERY_TIME_PS);

    // burst length in data beats (two per clock), latencies in clocks
    localparam int BURST_LENGTH         = 4;
    localparam int WRITE_LATENCY        = 3;
    localparam int READ_LATENCY_ROUNDED = 7;
    // read: earliest explicit precharge still delivering the burst
    localparam int READ_ACCESS_CYC  = BURST_LENGTH / 2;
    // write: burst end after write latency, then recovery
    localparam int WRITE_ACCESS_CYC = WRITE_LATENCY + BURST_LENGTH / 2 + WRECOVER_CYC;

    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;

    // ------------------------------------------------------------
    // command pins and encodings
    // ------------------------------------------------------------
    localparam int NUM_BANKS = 4;
    localparam int AUTO_PRECHARGE_SELECT_BIT = 8;
    localparam int ADDR_W = 12;
    // {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CMD_NOP       = 3'h7;
    localparam logic [2:0] CMD_ACTIVE    = 3'h3;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_MODE      = 3'h0;

    typedef enum logic [3:0] {
        BS_IDLE, BS_ACTIVATING, BS_ACTIVE, BS_READ, BS_WRITE,
        BS_PRECHARGING, BS_READ_AP, BS_WRITE_AP
    } sdbs_bank_e;

    typedef enum logic [1:0] {
        AS_NORMAL, AS_REFRESHING, AS_MODE_ACCESS, AS_PRECHARGE_ALL
    } sdbs_all_e;

endpackage

// *** src/sdbs_tracker.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Notes on behaviour
// RULE1 - tracking applies only with clock enable high twice
// RULE2 - idle only after precharge period elapsed
// RULE3 - row active after activate-to-access delay
// RULE4 - plain read or write keeps row open
// RULE5 - controller leaves busy bank alone
// RULE6 - activate starts activating, delay ends it
// RULE7 - precharge starts precharging, period ends it
// RULE8 - auto precharge access returns bank idle
// RULE9 - controller sends only no-ops during all-bank states
// RULE10 - refresh lasts refresh cycle time
// RULE11 - mode access lasts mode set delay
// RULE12 - precharge all idles every bank
// RULE13 - refresh and mode load need all idle
// RULE14 - multi-bank precharge needs valid targets
// RULE15 - write waits for read burst end
// RULE16 - controller masks unwanted write data
// RULE17 - banks operate independently of each other
// RULE18 - auto precharge splits into access, precharge
// RULE19 - read precharge starts at earliest explicit point
// RULE20 - write precharge starts after write recovery
// RULE21 - controller spaces commands after auto precharge
// RULE22 - controller avoids data bus collisions
// RULE23 - address bit eight selects auto precharge
// RULE24 - address bit eight on precharge selects all
// RULE25 - each bank keeps its own record
// ------------------------------------------------------------
module sdbs_tracker
    import sdbs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              clkEnable,
    input  wire logic              chipSelect_n,
    input  wire logic              rowStrobe_n,
    input  wire logic              colStrobe_n,
    input  wire logic              writeEnable_n,
    input  wire logic              bankSelectLow,
    input  wire logic              bankSelectHigh,
    input  wire logic [ADDR_W-1:0] addr,
    output logic [NUM_BANKS-1:0]   bankIdle,
    output logic [NUM_BANKS-1:0]   bankActive,
    output logic [NUM_BANKS-1:0]   bankBusy,
    output logic [NUM_BANKS-1:0]   bankPrechargePhase,
    output logic                   allBanksIdle,
    output logic                   refreshing,
    output logic                   modeAccess,
    output logic                   prechargeAll
);

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic             cke_q;
    logic [2:0]       cmdCode;
    logic             cmdValid;
    logic [1:0]       bankNum;
    logic             autoPre;
    sdbs_all_e        all_q, all_d;
    logic [TMR_W-1:0] atmr_q, atmr_d;

    // pins read as one code; chip select and clock enable gate it below
    assign cmdCode  = {rowStrobe_n, colStrobe_n, writeEnable_n};
    // commands count only with clock enable high at both edges
    assign cmdValid = !chipSelect_n && clkEnable && cke_q && (all_q == AS_NORMAL); // RULE1 RULE9
    assign bankNum  = {bankSelectHigh, bankSelectLow};
    assign autoPre  = addr[AUTO_PRECHARGE_SELECT_BIT];                            // RULE23

    sdbs_bank_e                 bankState [NUM_BANKS];
    logic       [NUM_BANKS-1:0] apPhase;
    logic       [NUM_BANKS-1:0] idle_d, act_d, busy_d;

    // ------------------------------------------------------------
    // per-bank records
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            logic hit;
            logic preSel;
            // only commands naming this bank reach it, except precharge all, which reaches every bank
            assign hit    = cmdValid && (bankNum == 2'(b));                // RULE17
            assign preSel = cmdValid && cmdCode == CMD_PRECHARGE && (autoPre || bankNum == 2'(b)); // RULE24
            sdbs_bank u_bank (                                              // RULE25
                .clk              (clk),
                .rst              (rst),
                .cmdValid         (hit),
                .cmdCode          (cmdCode),
                .autoPre          (autoPre),
                .preSelect        (preSel),
                .state            (bankState[b]),
                .apPrechargePhase (apPhase[b])
            );
            // flags decoded here so the outputs stay one flop behind the bank state records
            assign idle_d[b] = (bankState[b] == BS_IDLE);                   // RULE2
            assign act_d[b]  = (bankState[b] == BS_ACTIVE);                 // RULE3
            assign busy_d[b] = (bankState[b] == BS_ACTIVATING) || (bankState[b] == BS_PRECHARGING)
                            || (bankState[b] == BS_READ_AP) || (bankState[b] == BS_WRITE_AP);
        end
    endgenerate

    // ------------------------------------------------------------
    // all-bank states
    // ------------------------------------------------------------
    always_comb begin
        all_d  = all_q;
        atmr_d = (atmr_q != TMR_ZERO) ? atmr_q - 8'h01 : TMR_ZERO;
        unique case (all_q)
            AS_NORMAL: begin
                if (cmdValid && cmdCode == CMD_REFRESH) begin
                    all_d  = AS_REFRESHING;                               // RULE10
                    atmr_d = TMR_W'(REFRESH_CYC - 1);
                end else if (cmdValid && cmdCode == CMD_MODE) begin
                    all_d  = AS_MODE_ACCESS;                              // RULE11
                    atmr_d = TMR_W'(MODESET_CYC - 1);
                end else if (cmdValid && cmdCode == CMD_PRECHARGE && autoPre) begin
                    all_d  = AS_PRECHARGE_ALL;                            // RULE12
                    atmr_d = TMR_W'(PRECHARGE_CYC - 1);
                end
            end
            AS_REFRESHING, AS_MODE_ACCESS, AS_PRECHARGE_ALL: begin
                // nothing is taken here, so the timer cannot be restarted
                if (atmr_q == TMR_ZERO) all_d = AS_NORMAL;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers, outputs straight from flops
    // ------------------------------------------------------------
    // all-bank flags follow the next state; bank flags trail them by one clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cke_q              <= 1'b0;
            all_q              <= AS_NORMAL;
            atmr_q             <= TMR_ZERO;
            bankIdle           <= '1;
            bankActive         <= '0;
            bankBusy           <= '0;
            bankPrechargePhase <= '0;
            allBanksIdle       <= 1'b1;
            refreshing         <= 1'b0;
            modeAccess         <= 1'b0;
            prechargeAll       <= 1'b0;
        end else begin
            cke_q              <= clkEnable;
            all_q              <= all_d;
            atmr_q             <= atmr_d;
            bankIdle           <= idle_d;
            bankActive         <= act_d;
            bankBusy           <= busy_d;
            bankPrechargePhase <= apPhase;
            allBanksIdle       <= (&idle_d) && (all_d == AS_NORMAL);
            refreshing         <= (all_d == AS_REFRESHING);
            modeAccess         <= (all_d == AS_MODE_ACCESS);
            prechargeAll       <= (all_d == AS_PRECHARGE_ALL);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // repetition counts are the package timings in whole clocks
    refresh_length_a: assert property (@(posedge clk) disable iff (rst) // RULE10
        (cmdValid && cmdCode == CMD_REFRESH) |=> all_q == AS_REFRESHING [*8] ##1 all_q == AS_NORMAL)
        else $error("refresh state length wrong");

    mode_length_a: assert property (@(posedge clk) disable iff (rst) // RULE11
        (cmdValid && cmdCode == CMD_MODE) |=> all_q == AS_MODE_ACCESS [*2] ##1 all_q == AS_NORMAL)
        else $error("mode access length wrong");

    pre_all_a: assert property (@(posedge clk) disable iff (rst) // RULE12
        (cmdValid && cmdCode == CMD_PRECHARGE && autoPre) |=> ##4 (&bankIdle))
        else $error("banks not idle after precharge all");

    activate_delay_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        (cmdValid && cmdCode == CMD_ACTIVE && bankState[0] == BS_IDLE && bankNum == 2'h0)
        |=> bankState[0] == BS_ACTIVATING [*3] ##1 bankState[0] == BS_ACTIVE)
        else $error("activate delay wrong");

    precharge_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE7
        (bankState[0] == BS_PRECHARGING && $past(bankState[0]) == BS_ACTIVE)
        |-> bankState[0] == BS_PRECHARGING [*3] ##1 bankState[0] == BS_IDLE)
        else $error("precharge period wrong");

    open_row_a: assert property (@(posedge clk) disable iff (rst) // RULE4
        (cmdValid && cmdCode == CMD_READ && !autoPre && bankNum == 2'h0 && bankState[0] == BS_ACTIVE)
        |=> bankState[0] == BS_READ)
        else $error("row not left open");

    ap_read_a: assert property (@(posedge clk) disable iff (rst) // RULE19
        (cmdValid && cmdCode == CMD_READ && autoPre && bankNum == 2'h1 && bankState[1] == BS_ACTIVE)
        |=> !apPhase[1] [*2] ##1 apPhase[1] [*3] ##1 bankState[1] == BS_IDLE)
        else $error("read auto precharge timing wrong");

    ap_write_a: assert property (@(posedge clk) disable iff (rst) // RULE20
        (cmdValid && cmdCode == CMD_WRITE && autoPre && bankNum == 2'h2 && bankState[2] == BS_ACTIVE)
        |=> bankState[2] == BS_WRITE_AP && !apPhase[2] [*7] ##1 apPhase[2])
        else $error("write recovery not honoured");

    // clock enable low at the previous edge must leave an idle bank alone
    cke_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE1
        (!cke_q && bankState[2] == BS_IDLE) |=> bankState[2] == BS_IDLE)
        else $error("command taken with clock enable low");

    // output flags never claim two states for one bank
    flags_exclusive_a: assert property (@(posedge clk) disable iff (rst) // RULE2
        ((bankIdle & bankActive) | (bankIdle & bankBusy) | (bankActive & bankBusy)) == 4'h0)
        else $error("bank flags overlap");

    // an auto precharge phase only ever shows on a busy bank
    phase_in_busy_a: assert property (@(posedge clk) disable iff (rst) // RULE18
        (bankPrechargePhase & ~bankBusy) == 4'h0)
        else $error("precharge phase outside busy bank");

    // the summary flag must agree with the bank and all-bank flags
    all_idle_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE12
        allBanksIdle |-> (&bankIdle) && !refreshing && !modeAccess && !prechargeAll)
        else $error("all banks idle flag wrong");

endmodule
